// File: hw/lcd_map.svh
// Constants for the character display host port: timing figures and their cycle counts.
// Assumes the including file runs on mclk at the rate given here.
`ifndef LCD_MAP_SVH
`define LCD_MAP_SVH

`define LCD_MCLK_PERIOD_NS   40
`define LCD_POWERUP_NS       20000000
`define LCD_CLEAR_NS         1520000
`define LCD_RAM_ACCESS_NS    43000
`define LCD_INSTR_NS         37000

// Least times, rounded up to whole mclk cycles
`define LCD_POWERUP_CYC    ((`LCD_POWERUP_NS + `LCD_MCLK_PERIOD_NS - 1) / `LCD_MCLK_PERIOD_NS)
`define LCD_CLEAR_CYC      ((`LCD_CLEAR_NS + `LCD_MCLK_PERIOD_NS - 1) / `LCD_MCLK_PERIOD_NS)
`define LCD_RAM_ACCESS_CYC ((`LCD_RAM_ACCESS_NS + `LCD_MCLK_PERIOD_NS - 1) / `LCD_MCLK_PERIOD_NS)
`define LCD_INSTR_CYC      ((`LCD_INSTR_NS + `LCD_MCLK_PERIOD_NS - 1) / `LCD_MCLK_PERIOD_NS)

`define LCD_RAM_DEPTH      80
`define LCD_SPACE_CODE     8'h20
`define LCD_AC_RESET       7'h00
`define LCD_BUSY_BIT       7
`define LCD_WIDTH_BIT      4

`define LCD_CMD_CLEAR      8'h01
`define LCD_CMD_HOME_MASK  8'hfe
`define LCD_CMD_HOME       8'h02
`define LCD_CMD_FUNC_MASK  8'he0
`define LCD_CMD_FUNC       8'h20
`define LCD_CMD_ADDR_BIT   7

`endif

// File: hw/lcd_pkg.sv
// Types shared by the character display host port.
// Constants live in lcd_map.svh; this package holds only types.
package lcd_pkg;

  typedef struct packed {
    logic       register_select;
    logic       read_not_write;
    logic       enable;
    logic [7:0] data;
  } host_bus_t;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b001,
    ST_IDLE    = 3'b010,
    ST_BUSY    = 3'b100
  } port_state_t;

endpackage

// File: hw/char_lcd_powerup_busy_port.sv
// Host-facing parallel port of a character display controller with power-up busy.
// Assumes host pins are asynchronous to mclk and that the host holds each strobe
// well beyond four mclk cycles.
// Busy times count mclk cycles, so a slower mclk lengthens every wait.
// Single clock; nrst stands for the power-on reset of the device.
`timescale 1ns/1ps
`include "lcd_map.svh"

module char_lcd_powerup_busy_port #(
  parameter int unsigned POWERUP_CYCLES = `LCD_POWERUP_CYC,
  parameter int unsigned CLEAR_CYCLES   = `LCD_CLEAR_CYC,
  parameter int unsigned RAM_CYCLES     = `LCD_RAM_ACCESS_CYC,
  parameter int unsigned INSTR_CYCLES   = `LCD_INSTR_CYC
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       register_select,
  input  wire logic       read_not_write,
  input  wire logic       enable,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            busy
);

  localparam int unsigned DEPTH = `LCD_RAM_DEPTH;

  lcd_pkg::host_bus_t   pins;
  lcd_pkg::host_bus_t   sync1;
  lcd_pkg::host_bus_t   sync2;
  logic                 enable_prev;
  lcd_pkg::port_state_t state;
  lcd_pkg::port_state_t next_state;
  logic [19:0]          count;
  logic [19:0]          next_count;
  logic [6:0]           ac;
  logic [6:0]           next_ac;
  logic                 wide;
  logic                 next_wide;
  logic                 low_phase;
  logic [3:0]           upper;
  logic [7:0]           ram [0:DEPTH-1];

  assign pins = '{register_select, read_not_write, enable, data_in};

  // Pins come from the host's domain: two flops before anything reads them
  // The data bus crosses as a word; safe only because the host holds it
  // steady for the whole strobe and action waits for the falling edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
      enable_prev <= 1'b0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      enable_prev <= sync2.enable;
    end
  end

  // Strobe action happens on the falling enable edge, after the host has
  // held data stable for the whole pulse
  wire        strobe_fall = enable_prev & ~sync2.enable;
  wire        is_busy     = (state != lcd_pkg::ST_IDLE);
  wire        count_done  = (count == 20'h00000);
  wire        status_rd   = ~sync2.register_select & sync2.read_not_write;
  wire        byte_done   = wide | low_phase;
  wire [7:0]  in_byte     = wide ? sync2.data : {upper, sync2.data[7:4]};
  wire        accept      = strobe_fall & byte_done & ~is_busy;
  wire        do_instr    = accept & ~sync2.register_select & ~sync2.read_not_write;
  wire        do_wdata    = accept & sync2.register_select & ~sync2.read_not_write;
  wire        do_rdata    = accept & sync2.register_select & sync2.read_not_write;
  wire        cmd_clear   = do_instr & (in_byte == `LCD_CMD_CLEAR);
  wire        cmd_home    = do_instr & ((in_byte & `LCD_CMD_HOME_MASK) == `LCD_CMD_HOME);
  wire        cmd_func    = do_instr & ((in_byte & `LCD_CMD_FUNC_MASK) == `LCD_CMD_FUNC);
  wire        cmd_addr    = do_instr & in_byte[`LCD_CMD_ADDR_BIT];
  // The counter leaves the memory only through a set-address instruction
  wire        ac_in_range = (ac < 7'(DEPTH));
  wire [6:0]  ac_inc      = (ac >= 7'(DEPTH - 1)) ? `LCD_AC_RESET : ac + 7'h01;
  wire [7:0]  ram_word    = ac_in_range ? ram[ac] : 8'h00;
  wire [7:0]  status_word = {is_busy, ac};
  wire [7:0]  read_word   = status_rd ? status_word : ram_word;
  // In 4-bit mode the upper phase shows the whole byte and the lower phase
  // moves the low nibble onto the upper lines, so a host that reads only
  // the upper four lines gets the byte in two halves
  wire [3:0]  low_nibble  = read_word[3:0];
  wire        upper_lane  = wide | ~low_phase;
  wire [7:0]  lane_word   = upper_lane ? read_word : {low_nibble, 4'h0};

  // Next state, busy time and address counter
  always_comb begin
    next_state = state;
    next_count = count;
    next_ac    = ac;
    next_wide  = wide;
    case (state)
      lcd_pkg::ST_POWERUP: begin
        // Fixed cycle count: the delay scales with the clock rate
        if (count_done) begin
          next_state = lcd_pkg::ST_IDLE;
        end else begin
          next_count = count - 20'h00001;
        end
      end
      lcd_pkg::ST_IDLE: begin
        // Clear and home share the long busy time; home leaves memory alone
        if (cmd_clear || cmd_home) begin
          next_ac    = `LCD_AC_RESET;
          next_count = 20'(CLEAR_CYCLES - 1);
          next_state = lcd_pkg::ST_BUSY;
        end else if (do_wdata || do_rdata) begin
          // Reads and writes both step the address and wrap at the end
          next_ac    = ac_inc;
          next_count = 20'(RAM_CYCLES - 1);
          next_state = lcd_pkg::ST_BUSY;
        end else if (do_instr) begin
          // Any other instruction costs only the short busy time
          if (cmd_addr) begin
            next_ac = in_byte[6:0];
          end
          if (cmd_func) begin
            next_wide = in_byte[`LCD_WIDTH_BIT];
          end
          next_count = 20'(INSTR_CYCLES - 1);
          next_state = lcd_pkg::ST_BUSY;
        end
      end
      lcd_pkg::ST_BUSY: begin
        if (count_done) begin
          next_state = lcd_pkg::ST_IDLE;
        end else begin
          next_count = count - 20'h00001;
        end
      end
      default: begin
        next_state = lcd_pkg::ST_POWERUP;
        next_count = 20'(POWERUP_CYCLES - 1);
      end
    endcase
  end

  // Reset needs no host command: power-up busy starts from nrst alone
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= lcd_pkg::ST_POWERUP;
      count <= 20'(POWERUP_CYCLES - 1);
      ac    <= `LCD_AC_RESET;
      wide  <= 1'b1;
    end else begin
      state <= next_state;
      count <= next_count;
      ac    <= next_ac;
      wide  <= next_wide;
    end
  end

  // Nibble tracking runs even while busy so status polling stays aligned
  // Limitation: a host that ignores busy in 4-bit mode and loses count
  // must send a function set to bring the phase back to the upper nibble
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      low_phase <= 1'b0;
      upper     <= 4'h0;
    end else if (cmd_func) begin
      low_phase <= 1'b0;
    end else if (strobe_fall && !wide) begin
      low_phase <= ~low_phase;
      if (!low_phase) begin
        upper <= sync2.data[7:4];
      end
    end
  end

  // Display memory; reset and clear both fill it with spaces
  // Clear rewrites every cell in one cycle, trading area for speed; the
  // long busy time is kept for the host's sake, the memory needs none
  // Writes to addresses beyond the depth find no cell and are dropped
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_cell
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          ram[i] <= `LCD_SPACE_CODE;
        end else if (cmd_clear) begin
          ram[i] <= `LCD_SPACE_CODE;
        end else if (do_wdata && ac == 7'(i)) begin
          ram[i] <= in_byte;
        end
      end
    end
  endgenerate

  // Read data is registered; the host samples it late in its enable pulse
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_out <= 8'h00;
    end else begin
      data_out <= lane_word;
    end
  end

  // Follows the synchronised strobe: the bus is driven two cycles after
  // the pin rises and released two cycles after it falls
  assign data_oe = sync2.enable & sync2.read_not_write;
  // The state decode itself, so busy rises the cycle after a take
  assign busy    = is_busy;

endmodule // char_lcd_powerup_busy_port

// File: test/lcd_host.sv
// Host side of the display port: one enable strobe per call.
// The bench feeds back the resolved data bus on bus.
`timescale 1ns/1ps
module lcd_host (
  input  wire logic       mclk,
  input  wire logic [7:0] bus,
  output logic            rs,
  output logic            rw,
  output logic            en,
  output logic [7:0]      dout
);
  initial {rs, rw, en, dout} = 11'h000;
  // Five cycles high and low, above the four the port's synchroniser needs
  task automatic xfer(input logic [1:0] op, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk) #1;
    rs = op[1];
    rw = op[0];
    en = 1'b1;
    // A released bus shows the inverse, so no stale byte can pass for a reply
    dout = op[0] ? ~dout : d;
    repeat (5) @(posedge mclk);
    #1 q = bus;
    en = 1'b0;
    repeat (5) @(posedge mclk);
  endtask
endmodule // lcd_host

// File: test/lcd_port_checker.sv
// Checks on the display host port pins.
// Bound into the port, which hands on its cycle counts.
`timescale 1ns/1ps
module lcd_port_checker #(parameter int unsigned POWERUP_CYCLES = 50, CLEAR_CYCLES = 40,
  RAM_CYCLES = 10, INSTR_CYCLES = 8) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       register_select,
  input wire logic       read_not_write,
  input wire logic       enable,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       busy
);
  int unsigned up, len, want;
  // Nibble phase of the pins, so 4-bit transfers are judged per byte
  logic        narrow, half;
  logic [3:0]  hi;
  wire  [7:0]  byte_in = narrow ? {hi, data_in[7:4]} : data_in;
  wire         done    = !narrow || half;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      up <= 0;
      len <= 0;
      want <= 0;
      narrow <= 1'b0;
      half <= 1'b0;
      hi <= 4'h0;
    end else begin
      if (up < POWERUP_CYCLES + 4) up <= up + 1;
      len <= busy ? len + 1 : 0;
      if ($fell(enable)) begin
        if (done && !busy && !register_select && !read_not_write && byte_in[7:5] == 3'h1)
          narrow <= !byte_in[4];
        if (narrow) half <= !half;
        if (narrow && !half) hi <= data_in[7:4];
      end
      // Refused strobes are skipped so they cannot move the target
      if ($fell(enable) && !busy && done && (register_select || !read_not_write))
        want <= register_select ? RAM_CYCLES : (byte_in[7:2] == 6'h00 && byte_in[1:0] != 2'h0)
          ? CLEAR_CYCLES : INSTR_CYCLES;
    end
  end
  AST_RESET_BUSY: assert property ($rose(nrst) |-> busy && !data_oe) else $error("rst");
  AST_INIT_HOLD: assert property (up + 1 < POWERUP_CYCLES |-> busy) else $error("ini");
  AST_INIT_DONE: assert property (up == POWERUP_CYCLES + 2 |-> !busy) else $error("end");
  AST_STATUS_MSB: assert property ((!register_select && read_not_write)[*6] ##0
    data_oe && $stable(busy) && (!narrow || (!half && $stable(half))) |-> data_out[7] == busy)
    else $error("msb");
  AST_CMD_LEN: assert property ($fell(busy) && want != 0 |->
    len >= want && len <= want + 1) else $error("len");
  AST_STATUS_QUIET: assert property ($fell(enable) && !busy && !register_select
    && read_not_write |-> !busy[*6]) else $error("sts");
  AST_OE_CAUSE: assert property ($rose(data_oe) |-> $past(enable) && $past(read_not_write))
    else $error("oe");
  AST_OE_DROP: assert property (!enable[*4] |-> !data_oe) else $error("oed");
  cover property ($fell(busy) && want == CLEAR_CYCLES);
  cover property ($fell(busy) && want == RAM_CYCLES);
  cover property (data_oe && busy);
  cover property (narrow && half && data_oe);
endmodule // lcd_port_checker

bind char_lcd_powerup_busy_port lcd_port_checker #(.POWERUP_CYCLES(POWERUP_CYCLES),
  .CLEAR_CYCLES(CLEAR_CYCLES), .RAM_CYCLES(RAM_CYCLES), .INSTR_CYCLES(INSTR_CYCLES))
  u_lcd_port_checker (.mclk(mclk), .nrst(nrst), .register_select(register_select),
  .read_not_write(read_not_write), .enable(enable), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .busy(busy));

// File: test/char_lcd_powerup_busy_port_tb.sv
// Self-checking bench for the display host port, host model on the pins.
// The checker comes in by bind from its own file.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module char_lcd_powerup_busy_port_tb;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        rs, rw, en, oe, busy;
  logic [7:0]  dh, dout, q;
  wire  [7:0]  bus = oe ? dout : dh;
  int          err_count = 0, checked = 0;
  // Hex digits: op (2 data ram, 1 read), byte sent, byte expected on reads
  logic [17:0] rows [23] = '{18'h10000, 18'h08500, 18'h24100, 18'h10006, 18'h08500,
    18'h30041, 18'h00100, 18'h30020, 18'h00200, 18'h10000, 18'h02000, 18'h08000,
    18'h03000, 18'h25000, 18'h2a000, 18'h08000, 18'h03000, 18'h3005a, 18'h300a0,
    18'h10004, 18'h10040, 18'h03000, 18'h00000};
  always #20 mclk = ~mclk;
  char_lcd_powerup_busy_port #(.POWERUP_CYCLES(50), .CLEAR_CYCLES(40), .RAM_CYCLES(10),
    .INSTR_CYCLES(8)) u_char_lcd_powerup_busy_port (.mclk(mclk), .nrst(nrst),
    .register_select(rs), .read_not_write(rw), .enable(en), .data_in(bus),
    .data_out(dout), .data_oe(oe), .busy(busy));
  lcd_host u_lcd_host (.mclk(mclk), .bus(bus), .rs(rs), .rw(rw), .en(en), .dout(dh));
  task automatic stop_test;
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_idle;
    #1;
    for (int n = 0; n < 200 && busy !== 1'b0; n++) @(posedge mclk) #1;
    `CHK(busy, 1'b0)
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    #1 nrst = 1'b1;
    u_lcd_host.xfer(2'h1, 8'h00, q);
    `CHK(q[7], 1'b1)
    u_lcd_host.xfer(2'h2, 8'h77, q);
    wait_idle();
    foreach (rows[i]) begin
      wait_idle();
      u_lcd_host.xfer(rows[i][17:16], rows[i][15:8], q);
      if (rows[i][16]) `CHK(q, rows[i][7:0])
    end
    wait_idle();
    u_lcd_host.xfer(2'h0, 8'h01, q);
    u_lcd_host.xfer(2'h1, 8'h00, q);
    `CHK(q[7], 1'b1)
    u_lcd_host.xfer(2'h2, 8'h66, q);
    wait_idle();
    u_lcd_host.xfer(2'h3, 8'h00, q);
    `CHK(q, 8'h20)
    #1 nrst = 1'b0;
    #100 `CHK(busy, 1'b1)
    `CHK({oe, dout}, 9'h000)
    stop_test();
  end
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule // char_lcd_powerup_busy_port_tb
